// ===== wdtck_pkg.sv
`default_nettype none
package wdtck_pkg;
   localparam logic [7:0] OFF_TICK_CTL = 8'h14;
   localparam logic [7:0] OFF_TICK_FLG = 8'h15;
   localparam logic [7:0] OFF_WD_CTL = 8'h16;
   localparam logic [7:0] OFF_WD_RESTART = 8'h17;
   localparam logic [7:0] OFF_STATUS = 8'h18;
   localparam logic [7:0] KEY_FIRST = 8'h55;
   localparam logic [7:0] KEY_SECOND = 8'hAA;
   localparam int TC_IRQ_EN = 7;
   localparam int TC_STOP_WAIT = 6;
   localparam int TC_STOP_DBG = 5;
   localparam int TC_BYPASS = 3;
   localparam int WC_CM_EN = 7;
   localparam int WC_CM_FORCE = 6;
   localparam int WC_FORCE_FAIL = 5;
   localparam int WC_WINDOW = 4;
   localparam int WC_RST_DIS = 3;
   localparam int FLG_TICK = 7;
   localparam logic [7:0] TICK_CTL_RST = 8'h00;
   localparam logic [7:0] WD_CTL_RST_NORMAL = 8'h07;
   localparam logic [7:0] WD_CTL_RST_SPECIAL = 8'h0F;
   localparam int BYPASS_DIV_LOG2 = 2;
   localparam int TICK_BASE_LOG2 = 13;
   localparam int WD_CNT_W = 24;
   localparam int CM_TIMEOUT_NS = 2000;
   localparam int CLK_PERIOD_NS = 5;
   localparam int CM_TIMEOUT_CYC = CM_TIMEOUT_NS / CLK_PERIOD_NS;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } wdtck_bus_t;
   typedef struct packed {
      logic wd_fail;
      logic cm_fail;
      logic limp_home;
   } wdtck_fail_t;
endpackage
`default_nettype wire

// ===== wdtck_top.sv
// Function
// - Any restart-register value other than the two keys resets the system.
// - Windowed mode: key writes before the final quarter cause reset.
// - Rate code 0 disables; 1..7 divide by 2^13,15,17,19,21,22,23.
// - Second key restarts time-out; windowed next write awaits next window.
// - Reset-disable blocks every watchdog and monitor reset; special-only write.
// - Tick interrupt request follows flag while enable bit 7 is one.
// - Stop-in-wait halts tick and watchdog in wait; write-once normally.
// - Stop-in-debug halts tick and watchdog in debug; write-once normally.
// - Bypass bit, special only, makes tick base divide by 4.
// - Tick rate 0 off; 1..7 divide by 2^13 through 2^19.
// - Tick flag set on period end; cleared by writing one.
// - Monitor delay independent of crystal; no edge signals clock failure.
// - Monitor enable catches stopped clocks; ignored while force bit set.
// - Clock loss enters limp-home unless no-limp-home set, then resets.
// - Force bit write-once normally; keeps monitoring on until reset.
// - Forced-failure bit, special only, forces failures per enabled units.
// - Both enabled gives both failures; under reset-disable only limp-home still follows.
// - Reset: rate 111, window off, reset-disable 0 normal, 1 special.
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module wdtck_top (
   input wire logic clk,
   input wire logic rst,
   input wire logic special_mode,
   input wire logic in_wait,
   input wire logic in_debug,
   input wire logic stop_mode,
   input wire logic no_limp_home,
   input wire logic crystal_clock,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   output logic tick_irq,
   output logic wd_reset_req,
   output logic cm_reset_req,
   output logic limp_home
);
   localparam int WD_W = wdtck_pkg::WD_CNT_W;
   wdtck_pkg::wdtck_bus_t bus;
   wdtck_pkg::wdtck_fail_t fail;
   logic [7:0] tick_control;
   logic [7:0] watchdog_control;
   logic tick_flag;
   logic wait_lock, dbg_lock, force_lock, wdctl_lock;
   logic [18:0] tick_div;
   logic [WD_W-1:0] wd_cnt;
   logic key_armed;
   logic halted;
   logic xtal_q, xtal_edge;
   logic [8:0] cm_cnt;
   logic cm_on;
   logic cm_lost;
   logic wd_viol;
   logic tick_tc;
   logic [WD_W-1:0] wd_limit;
   logic wd_in_window;
   logic wd_on;
   logic [18:0] tick_limit;

   assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

   function automatic logic [4:0] wd_log2(input logic [2:0] c);
      unique case (c)
         3'h1: wd_log2 = 5'h0D;
         3'h2: wd_log2 = 5'h0F;
         3'h3: wd_log2 = 5'h11;
         3'h4: wd_log2 = 5'h13;
         3'h5: wd_log2 = 5'h15;
         3'h6: wd_log2 = 5'h16;
         default: wd_log2 = 5'h17;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Register writes with write-once locks.
   always_ff @(posedge clk) begin
      if (rst) begin
         tick_control <= wdtck_pkg::TICK_CTL_RST;
         wait_lock <= 1'b0;
         dbg_lock <= 1'b0;
      end else if (bus.wr && bus.addr == wdtck_pkg::OFF_TICK_CTL) begin
         tick_control[wdtck_pkg::TC_IRQ_EN] <= bus.wdata[7];
         tick_control[2:0] <= bus.wdata[2:0];
         if (special_mode || !wait_lock) begin
            tick_control[wdtck_pkg::TC_STOP_WAIT] <= bus.wdata[6];
            wait_lock <= 1'b1;
         end
         if (special_mode || !dbg_lock) begin
            tick_control[wdtck_pkg::TC_STOP_DBG] <= bus.wdata[5];
            dbg_lock <= 1'b1;
         end
         if (special_mode) begin
            tick_control[wdtck_pkg::TC_BYPASS] <= bus.wdata[3];
         end
      end
   end

   // Reset value of reset-disable depends on the mode strap; the rate resets to 111 in both.
   always_ff @(posedge clk) begin
      if (rst) begin
         watchdog_control <= special_mode ? wdtck_pkg::WD_CTL_RST_SPECIAL
                                          : wdtck_pkg::WD_CTL_RST_NORMAL;
         watchdog_control[wdtck_pkg::WC_CM_EN] <= 1'b1;
         force_lock <= 1'b0;
         wdctl_lock <= 1'b0;
      end else if (bus.wr && bus.addr == wdtck_pkg::OFF_WD_CTL) begin
         watchdog_control[wdtck_pkg::WC_CM_EN] <= bus.wdata[7];
         if (special_mode || !force_lock) begin
            watchdog_control[wdtck_pkg::WC_CM_FORCE] <= bus.wdata[6];
            force_lock <= 1'b1;
         end
         if (special_mode || !wdctl_lock) begin
            watchdog_control[wdtck_pkg::WC_WINDOW] <= bus.wdata[4];
            watchdog_control[2:0] <= bus.wdata[2:0];
            wdctl_lock <= 1'b1;
         end
         if (special_mode) begin
            watchdog_control[wdtck_pkg::WC_FORCE_FAIL] <= bus.wdata[5];
            watchdog_control[wdtck_pkg::WC_RST_DIS] <= bus.wdata[3];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rdata <= 8'h00;
      end else if (bus.rd) begin
         unique case (bus.addr)
            wdtck_pkg::OFF_TICK_CTL: rdata <= tick_control;
            wdtck_pkg::OFF_TICK_FLG: rdata <= {tick_flag, 7'h00};
            wdtck_pkg::OFF_WD_CTL: rdata <= watchdog_control;
            wdtck_pkg::OFF_STATUS: rdata <= {5'h00, fail};
            default: rdata <= 8'h00;
         endcase
      end else begin
         rdata <= 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Periodic tick.
   assign halted = (in_wait && tick_control[wdtck_pkg::TC_STOP_WAIT])
                || (in_debug && tick_control[wdtck_pkg::TC_STOP_DBG]);
   always_comb begin
      if (tick_control[wdtck_pkg::TC_BYPASS]) begin
         tick_limit = 19'((1 << wdtck_pkg::BYPASS_DIV_LOG2)
                      << (tick_control[2:0] - 3'h1)) - 19'h1;
      end else begin
         tick_limit = 19'((1 << wdtck_pkg::TICK_BASE_LOG2)
                      << (tick_control[2:0] - 3'h1)) - 19'h1;
      end
   end
   // A shorter rate written mid-count must not leave the divider past its end.
   assign tick_tc = tick_control[2:0] != 3'h0 && tick_div >= tick_limit;

   always_ff @(posedge clk) begin
      if (rst || tick_control[2:0] == 3'h0) begin
         tick_div <= 19'h0;
      end else if (!halted) begin
         tick_div <= tick_tc ? 19'h0 : tick_div + 19'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         tick_flag <= 1'b0;
      end else if (tick_tc && !halted) begin
         tick_flag <= 1'b1;
      end else if (bus.wr && bus.addr == wdtck_pkg::OFF_TICK_FLG
                   && bus.wdata[wdtck_pkg::FLG_TICK]) begin
         tick_flag <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         tick_irq <= 1'b0;
      end else begin
         tick_irq <= tick_flag && tick_control[wdtck_pkg::TC_IRQ_EN];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Watchdog.
   assign wd_on = watchdog_control[2:0] != 3'h0;
   assign wd_limit = WD_W'((1 << wd_log2(watchdog_control[2:0])) - 1);
   assign wd_in_window = wd_cnt >= WD_W'(3 << (wd_log2(watchdog_control[2:0])
                                               - 5'h2));

   always_comb begin
      wd_viol = 1'b0;
      if (wd_on && wd_cnt == wd_limit && !halted) begin
         wd_viol = 1'b1;
      end
      if (bus.wr && bus.addr == wdtck_pkg::OFF_WD_RESTART) begin
         if (bus.wdata != wdtck_pkg::KEY_FIRST
             && bus.wdata != wdtck_pkg::KEY_SECOND) begin
            wd_viol = 1'b1;
         end else if (wd_on && watchdog_control[wdtck_pkg::WC_WINDOW]
                      && !wd_in_window) begin
            wd_viol = 1'b1;
         end
      end
      if (watchdog_control[wdtck_pkg::WC_FORCE_FAIL] && wd_on) begin
         wd_viol = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wd_cnt <= '0;
         key_armed <= 1'b0;
      end else if (bus.wr && bus.addr == wdtck_pkg::OFF_WD_RESTART) begin
         if (bus.wdata == wdtck_pkg::KEY_FIRST) begin
            key_armed <= 1'b1;
         end else if (bus.wdata == wdtck_pkg::KEY_SECOND && key_armed) begin
            key_armed <= 1'b0;
            wd_cnt <= '0;
         end
      end else if (wd_on && !halted) begin
         wd_cnt <= wd_cnt + WD_W'(1);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Clock monitor: free-running delay counter on the fast clock stands in
   // for the RC delay, so it keeps counting when the crystal stops.
   always_ff @(posedge clk) begin
      if (rst) begin
         xtal_q <= 1'b0;
      end else begin
         xtal_q <= crystal_clock;
      end
   end
   assign xtal_edge = xtal_q != crystal_clock;
   assign cm_on = watchdog_control[wdtck_pkg::WC_CM_FORCE]
               || watchdog_control[wdtck_pkg::WC_CM_EN];

   always_ff @(posedge clk) begin
      if (rst || xtal_edge || !cm_on) begin
         cm_cnt <= 9'h0;
      end else if (cm_cnt != 9'(wdtck_pkg::CM_TIMEOUT_CYC)) begin
         cm_cnt <= cm_cnt + 9'h1;
      end
   end
   assign cm_lost = (cm_on && (stop_mode
                     || cm_cnt == 9'(wdtck_pkg::CM_TIMEOUT_CYC)))
                 || (watchdog_control[wdtck_pkg::WC_FORCE_FAIL]
                     && watchdog_control[wdtck_pkg::WC_CM_EN]);

   always_ff @(posedge clk) begin
      if (rst) begin
         wd_reset_req <= 1'b0;
         cm_reset_req <= 1'b0;
         limp_home <= 1'b0;
      end else begin
         wd_reset_req <= wd_viol && !watchdog_control[wdtck_pkg::WC_RST_DIS];
         cm_reset_req <= cm_lost && no_limp_home
                      && !watchdog_control[wdtck_pkg::WC_RST_DIS];
         limp_home <= cm_lost && !no_limp_home;
      end
   end
   assign fail = '{wd_fail: wd_reset_req, cm_fail: cm_reset_req,
                   limp_home: limp_home};

   ////////////////////////////////////////////////////////////////////////
   a_irq_follow: assert property (@(posedge clk) disable iff (rst)
      ##1 tick_irq == $past(tick_flag && tick_control[7]))
      else $error("tick irq wrong");
   a_flag_clear: assert property (@(posedge clk) disable iff (rst)
      wr && addr == 8'h15 && wdata[7] && !(tick_tc && !halted) |=> !tick_flag)
      else $error("flag not cleared");
   a_bad_key: assert property (@(posedge clk) disable iff (rst)
      wr && addr == 8'h17 && wdata != 8'h55 && wdata != 8'hAA
      && !watchdog_control[3] |=> wd_reset_req)
      else $error("bad key no reset");
   a_reset_disable_block: assert property (@(posedge clk) disable iff (rst)
      $past(watchdog_control[3]) |-> !wd_reset_req && !cm_reset_req)
      else $error("reset while disabled");
   a_wd_off: assert property (@(posedge clk) disable iff (rst)
      watchdog_control[2:0] == 3'h0 |=> wd_cnt == $past(wd_cnt) || wd_cnt == 0)
      else $error("watchdog counts while off");
   a_limp_sel: assert property (@(posedge clk) disable iff (rst)
      cm_lost && !no_limp_home |=> limp_home && !cm_reset_req)
      else $error("limp select wrong");
   a_restart: assert property (@(posedge clk) disable iff (rst)
      wr && addr == 8'h17 && wdata == 8'hAA && key_armed |=> wd_cnt == 0)
      else $error("no restart");
   a_halt_tick: assert property (@(posedge clk) disable iff (rst)
      halted && tick_control[2:0] != 0 ##1 tick_control[2:0] != 0
      |-> tick_div == $past(tick_div))
      else $error("tick runs while halted");
   a_early_key: assert property (@(posedge clk) disable iff (rst)
      bus.wr && bus.addr == wdtck_pkg::OFF_WD_RESTART
      && (bus.wdata == wdtck_pkg::KEY_FIRST
          || bus.wdata == wdtck_pkg::KEY_SECOND)
      && wd_on && watchdog_control[wdtck_pkg::WC_WINDOW] && !wd_in_window
      && !watchdog_control[wdtck_pkg::WC_RST_DIS] |=> wd_reset_req)
      else $error("early key no reset");
   a_force_lock: assert property (@(posedge clk) disable iff (rst)
      force_lock && !special_mode
      |=> $stable(watchdog_control[wdtck_pkg::WC_CM_FORCE]))
      else $error("force bit changed after lock");
endmodule
`default_nettype wire

// ===== tb_wdtck_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_wdtck_top;
   logic clk, rst, special_mode, in_wait, in_debug, stop_mode;
   logic no_limp_home, crystal_clock, wr, rd, xrun;
   logic [7:0] addr, wdata, rdata;
   logic tick_irq, wd_reset_req, cm_reset_req, limp_home;
   int err_total, cmp_count, cyc;
   typedef struct {
      logic [7:0] a;
      logic [7:0] d;
      logic [7:0] e;
   } wdtck_row_t;
   wdtck_row_t rows [8];

   wdtck_top wdtck_top_i (.clk(clk), .rst(rst), .special_mode(special_mode),
      .in_wait(in_wait), .in_debug(in_debug), .stop_mode(stop_mode),
      .no_limp_home(no_limp_home), .crystal_clock(crystal_clock),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .tick_irq(tick_irq), .wd_reset_req(wd_reset_req),
      .cm_reset_req(cm_reset_req), .limp_home(limp_home));

   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // The crystal toggles every cycle while running, so the monitor is fed.
   always @(posedge clk) begin
      if (xrun) begin
         crystal_clock <= ~crystal_clock;
      end
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         err_total = err_total + 1;
         wrap_up();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic wrap_up();
      $display("errors %0d compares %0d", err_total, cmp_count);
      if (err_total == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdata, e);
   endtask

   function automatic logic [7:0] outs(input int s);
      case (s)
         0: return {7'h00, tick_irq};
         1: return {7'h00, wd_reset_req};
         2: return {7'h00, cm_reset_req};
         default: return {7'h00, limp_home};
      endcase
   endfunction

   // Output must be low after lo cycles (checked once, only if lo > 0), then must rise within hi cycles.
   task automatic ewin(input int s, input int lo, input int hi);
      int n;
      n = 0;
      repeat (lo) @(posedge clk);
      #1;
      if (lo > 0) begin
         chk(outs(s), 8'h00);
      end
      while (outs(s) !== 8'h01 && n < hi) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk(outs(s), 8'h01);
   endtask

   task automatic quiet(input int s, input int n);
      repeat (n) @(posedge clk);
      #1;
      chk(outs(s), 8'h00);
   endtask

   task automatic do_rst(input logic sp);
      @(posedge clk);
      special_mode <= sp;
      xrun <= 1'b1;
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      #1;
      chk({4'h0, tick_irq, wd_reset_req, cm_reset_req, limp_home}, 8'h00);
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      rst = 1'b1;
      special_mode = 1'b0;
      in_wait = 1'b0;
      in_debug = 1'b0;
      stop_mode = 1'b0;
      no_limp_home = 1'b0;
      crystal_clock = 1'b0;
      xrun = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      addr = 8'h00;
      wdata = 8'h00;
      err_total = 0;
      cmp_count = 0;
      cyc = 0;
      rows = '{'{8'h14, 8'h89, 8'h81}, '{8'h14, 8'hE1, 8'h81},
               '{8'h16, 8'h81, 8'h81}, '{8'h16, 8'h0A, 8'h01},
               '{8'h16, 8'h81, 8'h81}, '{8'h20, 8'hFF, 8'h00},
               '{8'h17, 8'h55, 8'h00}, '{8'h17, 8'hAA, 8'h00}};
      do_rst(1'b0);
      rchk(8'h16, 8'h87);
      rchk(8'h14, 8'h00);
      foreach (rows[i]) begin
         wreg(rows[i].a, rows[i].d);
         rchk(rows[i].a, rows[i].e);
      end
      quiet(1, 4000);
      wreg(8'h17, 8'h55);
      wreg(8'h17, 8'hAA);
      quiet(1, 5000);
      rchk(8'h15, 8'h80);
      chk(outs(0), 8'h01);
      ewin(1, 3000, 300);
      do_rst(1'b0);
      rchk(8'h15, 8'h00);
      wreg(8'h16, 8'h92);
      wreg(8'h17, 8'h55);
      ewin(1, 0, 5);
      do_rst(1'b0);
      @(posedge clk);
      xrun <= 1'b0;
      ewin(3, 380, 40);
      rchk(8'h18, 8'h01);
      do_rst(1'b0);
      @(posedge clk);
      stop_mode <= 1'b1;
      ewin(3, 0, 3);
      @(posedge clk);
      stop_mode <= 1'b0;
      wreg(8'h16, 8'h47);
      rchk(8'h16, 8'h47);
      wreg(8'h16, 8'h07);
      rchk(8'h16, 8'h47);
      @(posedge clk);
      no_limp_home <= 1'b1;
      xrun <= 1'b0;
      ewin(2, 380, 40);
      rchk(8'h18, 8'h02);
      do_rst(1'b1);
      rchk(8'h16, 8'h8F);
      wreg(8'h17, 8'h33);
      quiet(1, 0);
      wreg(8'h16, 8'h2F);
      quiet(1, 20);
      wreg(8'h16, 8'h27);
      ewin(1, 0, 5);
      chk(outs(2), 8'h00);
      wreg(8'h16, 8'h20);
      quiet(1, 2);
      chk(outs(2), 8'h00);
      do_rst(1'b1);
      wreg(8'h16, 8'hA7);
      ewin(1, 0, 5);
      ewin(2, 0, 5);
      rchk(8'h18, 8'h06);
      do_rst(1'b1);
      wreg(8'h16, 8'h91);
      repeat (6300) @(posedge clk);
      wreg(8'h17, 8'h55);
      quiet(1, 0);
      wreg(8'h17, 8'hAA);
      quiet(1, 0);
      wreg(8'h17, 8'h55);
      ewin(1, 0, 5);
      do_rst(1'b1);
      wreg(8'h14, 8'h89);
      ewin(0, 0, 40);
      wreg(8'h14, 8'h09);
      quiet(0, 3);
      rchk(8'h15, 8'h80);
      wreg(8'h14, 8'h88);
      wreg(8'h15, 8'h80);
      wreg(8'h14, 8'h8B);
      ewin(0, 12, 8);
      for (int i = 0; i < 2; i++) begin
         wreg(8'h14, (i == 0) ? 8'h49 : 8'h29);
         in_wait <= (i == 0);
         in_debug <= (i == 1);
         repeat (3) @(posedge clk);
         wreg(8'h15, 8'h80);
         repeat (40) @(posedge clk);
         rchk(8'h15, 8'h00);
      end
      wrap_up();
   end
endmodule
`default_nettype wire
